//--- common/lsio_pkg.sv
package lsio_pkg;

  localparam int unsigned AddrWidth = 12;
  localparam int unsigned PortWidth = 8;

  // Register byte addresses
  localparam logic [11:0] AddrP8Data = 12'h000;
  localparam logic [11:0] AddrP8Dir = 12'h004;
  localparam logic [11:0] AddrP9Data = 12'h008;
  localparam logic [11:0] AddrP9Dir = 12'h00C;
  localparam logic [11:0] AddrLcdCtrl = 12'h010;

  // Control register field positions
  localparam int unsigned SegSelLsb = 0;
  localparam int unsigned SegExtBit = 4;
  localparam int unsigned SegCtrlWidth = 5;

  // Reset values, and the value a direction register reads as
  localparam logic [7:0] PortDataReset = 8'h00;
  localparam logic [7:0] PortDirReset = 8'h00;
  localparam logic [4:0] LcdCtrlReset = 5'h00;
  localparam logic [7:0] DirReadValue = 8'hFF;

  // Segment numbering of the shared pins
  localparam int unsigned P8SegBase = 25;
  localparam int unsigned P9Seg6 = 39;
  localparam int unsigned P9Seg7 = 40;

  // Power modes of the chip
  typedef enum logic [2:0] {
    LSIO_ACTIVE = 3'b000,
    LSIO_SUBACTIVE = 3'b001,
    LSIO_SLEEP = 3'b010,
    LSIO_SUBSLEEP = 3'b011,
    LSIO_WATCH = 3'b100,
    LSIO_STANDBY = 3'b101
  } lsio_mode_type;

endpackage : lsio_pkg

//--- hw/lsio_ports.sv
// Our own choices: the register offsets and register access over APB.
module lsio_ports
  import lsio_pkg::*;
#(
  parameter int unsigned Width = PortWidth
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AddrWidth-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire lsio_mode_type powerMode,
  input wire logic [Width-1:0] lcdSegEight,
  input wire logic lcdSegNine6,
  input wire logic lcdSegNine7,
  input wire logic lcdClockOne,
  input wire logic lcdClockTwo,
  input wire logic [Width-1:0] portEightIn,
  output logic [Width-1:0] portEightOut,
  output logic [Width-1:0] portEightOe_n,
  input wire logic [Width-1:0] portNineIn,
  output logic [Width-1:0] portNineOut,
  output logic [Width-1:0] portNineOe_n
);

  typedef struct packed {
    logic [Width-1:0] p8Data;
    logic [Width-1:0] p8Dir;
    logic [Width-1:0] p9Data;
    logic [Width-1:0] p9Dir;
    logic [SegCtrlWidth-1:0] lcdCtrl;
    logic [Width-1:0] p8Out;
    logic [Width-1:0] p8OeN;
    logic [Width-1:0] p9Out;
    logic [Width-1:0] p9OeN;
    logic [31:0] rdata;
    logic started;
  } lsio_state_type;

  lsio_state_type state_q;
  lsio_state_type state_d;

  logic [3:0] segSel;
  logic segExt;
  logic [Width-1:0] p8Gpio;
  logic [Width-1:0] p9Gpio;
  logic [Width-1:0] p8Pin;
  logic [Width-1:0] p9Pin;
  logic [Width-1:0] p8PinOe;
  logic [Width-1:0] p9PinOe;
  logic hiZ;
  logic holdPins;
  logic wrEn;
  logic rdEn;
  logic addrOk;

  // Read-back mix: stored data for outputs in I/O mode, live level for all other pins
  function automatic logic [Width-1:0] portRead(
    input logic [Width-1:0] dir,
    input logic [Width-1:0] data,
    input logic [Width-1:0] pins,
    input logic [Width-1:0] gpio
  );
    portRead = (dir & gpio & data) | (~(dir & gpio) & pins);
  endfunction : portRead

  assign segSel = state_q.lcdCtrl[SegSelLsb +: 4];
  assign segExt = state_q.lcdCtrl[SegExtBit];

  always_comb begin
    for (int i = 0; i < Width; i++) begin
      if (i >= 4) begin
        p8Gpio[i] = (segSel[3:1] == 3'b000);
      end else begin
        p8Gpio[i] = (segSel[3:1] == 3'b000) || (segSel == 4'b0010);
      end
      if (i >= 6) begin
        p9Gpio[i] = !segExt && (segSel == 4'b0000);
      end else begin
        p9Gpio[i] = (segSel == 4'b0000);
      end
    end
  end

  always_comb begin
    for (int i = 0; i < Width; i++) begin
      p8Pin[i] = p8Gpio[i] ? state_q.p8Data[i] : lcdSegEight[i];
      p8PinOe[i] = p8Gpio[i] ? state_q.p8Dir[i] : 1'b1;
      p9Pin[i] = state_q.p9Data[i];
      p9PinOe[i] = p9Gpio[i] ? state_q.p9Dir[i] : (i >= 6);
    end
    if (!p9Gpio[7]) begin
      p9Pin[7] = segExt ? lcdClockOne : lcdSegNine7;
    end
    if (!p9Gpio[6]) begin
      p9Pin[6] = segExt ? lcdClockTwo : lcdSegNine6;
    end
  end

  assign hiZ = (powerMode == LSIO_STANDBY) || !state_q.started;
  assign holdPins = (powerMode == LSIO_SLEEP) || (powerMode == LSIO_SUBSLEEP)
      || (powerMode == LSIO_WATCH);

  assign addrOk = (paddr == AddrP8Data) || (paddr == AddrP8Dir) || (paddr == AddrP9Data)
      || (paddr == AddrP9Dir) || (paddr == AddrLcdCtrl);
  assign wrEn = psel && penable && pwrite && addrOk;
  assign rdEn = psel && !penable && !pwrite;

  always_comb begin
    state_d = state_q;
    state_d.started = 1'b1;
    if (wrEn) begin
      unique case (paddr)
        AddrP8Data: state_d.p8Data = pwdata[Width-1:0];
        AddrP8Dir: state_d.p8Dir = pwdata[Width-1:0];
        AddrP9Data: state_d.p9Data = pwdata[Width-1:0];
        AddrP9Dir: state_d.p9Dir = pwdata[Width-1:0];
        AddrLcdCtrl: state_d.lcdCtrl = pwdata[SegCtrlWidth-1:0];
        default: state_d.p8Data = state_q.p8Data;
      endcase
    end
    if (rdEn) begin
      state_d.rdata = 32'h0000_0000;
      unique case (paddr)
        AddrP8Data: state_d.rdata[Width-1:0] =
            portRead(state_q.p8Dir, state_q.p8Data, portEightIn, p8Gpio);
        AddrP8Dir: state_d.rdata[Width-1:0] = DirReadValue;
        AddrP9Data: state_d.rdata[Width-1:0] =
            portRead(state_q.p9Dir, state_q.p9Data, portNineIn, p9Gpio);
        AddrP9Dir: state_d.rdata[Width-1:0] = DirReadValue;
        AddrLcdCtrl: state_d.rdata[SegCtrlWidth-1:0] = state_q.lcdCtrl;
        default: state_d.rdata = 32'h0000_0000;
      endcase
    end
    if (hiZ) begin
      state_d.p8OeN = '1;
      state_d.p9OeN = '1;
      state_d.p8Out = '0;
      state_d.p9Out = '0;
    end else if (!holdPins) begin
      state_d.p8Out = p8Pin;
      state_d.p9Out = p9Pin;
      state_d.p8OeN = ~p8PinOe;
      state_d.p9OeN = ~p9PinOe;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_q.p8Data <= PortDataReset;
      state_q.p8Dir <= PortDirReset;
      state_q.p9Data <= PortDataReset;
      state_q.p9Dir <= PortDirReset;
      state_q.lcdCtrl <= LcdCtrlReset;
      state_q.p8Out <= '0;
      state_q.p9Out <= '0;
      state_q.p8OeN <= '1;
      state_q.p9OeN <= '1;
      state_q.rdata <= 32'h0000_0000;
      state_q.started <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  assign prdata = state_q.rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addrOk;
  assign portEightOut = state_q.p8Out;
  assign portEightOe_n = state_q.p8OeN;
  assign portNineOut = state_q.p9Out;
  assign portNineOe_n = state_q.p9OeN;

  chk_dir_reads_ones: assert property (@(posedge ref_clk) disable iff (!rst_n)
      psel && !penable && !pwrite && paddr == AddrP9Dir |=> prdata[7:0] == 8'hFF)
    else $error("direction read not all ones");

  chk_p9_reset_zero: assert property (@(posedge ref_clk)
      !rst_n |=> state_q.p9Dir == 8'h00 && state_q.p9Data == 8'h00)
    else $error("port nine registers not cleared");

  chk_reset_hiz: assert property (@(posedge ref_clk)
      !rst_n |=> portEightOe_n == 8'hFF && portNineOe_n == 8'hFF)
    else $error("pins driven during reset");

  chk_standby_hiz: assert property (@(posedge ref_clk) disable iff (!rst_n)
      powerMode == LSIO_STANDBY |=> portNineOe_n == 8'hFF && portEightOe_n == 8'hFF)
    else $error("pins driven in standby");

  chk_sleep_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
      holdPins && $past(holdPins) && !$past(hiZ) |=> $stable(portNineOut) && $stable(portNineOe_n))
    else $error("pins changed while held");

  chk_p8_high_seg: assert property (@(posedge ref_clk) disable iff (!rst_n)
      segSel == 4'b0010 && !hiZ && !holdPins |=> portEightOe_n[7:4] == 4'h0)
    else $error("port eight high pins not segment");

  chk_p8_low_gpio: assert property (@(posedge ref_clk) disable iff (!rst_n)
      segSel == 4'b0010 && !hiZ && !holdPins |=> portEightOe_n[3:0] == ~$past(state_q.p8Dir[3:0]))
    else $error("port eight low pins not I/O");

  chk_clock_one: assert property (@(posedge ref_clk) disable iff (!rst_n)
      segExt && !hiZ && !holdPins |=> portNineOut[7] == $past(lcdClockOne) && !portNineOe_n[7])
    else $error("clock one not on pin");

  chk_p9_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
      rdEn && paddr == AddrP9Data && segSel == 4'b0000 && state_q.p9Dir == 8'h00
      |=> prdata[7:0] == $past(portNineIn))
    else $error("input pins not read back");

  chk_p8_high_gpio: assert property (@(posedge ref_clk) disable iff (!rst_n)
      segSel[3:1] == 3'b000 && !hiZ && !holdPins
      |=> portEightOe_n[7:4] == ~$past(state_q.p8Dir[7:4]))
    else $error("port eight high pins not I/O");

  chk_p8_high_data: assert property (@(posedge ref_clk) disable iff (!rst_n)
      segSel[3:1] == 3'b000 && !hiZ && !holdPins
      |=> portEightOut[7:4] == $past(state_q.p8Data[7:4]))
    else $error("port eight high pins lost data");

  chk_p8_high_segment: assert property (@(posedge ref_clk) disable iff (!rst_n)
      segSel[3:1] != 3'b000 && !hiZ && !holdPins
      |=> portEightOe_n[7:4] == 4'h0 && portEightOut[7:4] == $past(lcdSegEight[7:4]))
    else $error("port eight high pins miss segment");

  chk_p8_low_segment: assert property (@(posedge ref_clk) disable iff (!rst_n)
      segSel[3:1] != 3'b000 && segSel != 4'b0010 && !hiZ && !holdPins
      |=> portEightOe_n[3:0] == 4'h0 && portEightOut[3:0] == $past(lcdSegEight[3:0]))
    else $error("port eight low pins miss segment");

  chk_p8_low_data: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (segSel[3:1] == 3'b000 || segSel == 4'b0010) && !hiZ && !holdPins
      |=> portEightOut[3:0] == $past(state_q.p8Data[3:0]))
    else $error("port eight low pins lost data");

  chk_p8_standby: assert property (@(posedge ref_clk) disable iff (!rst_n)
      powerMode == LSIO_STANDBY
      |=> portEightOe_n == 8'hFF)
    else $error("port eight driven in standby");

  chk_p8_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
      holdPins && !hiZ
      |=> $stable(portEightOut) && $stable(portEightOe_n))
    else $error("port eight changed while held");

  chk_p8_functional: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (powerMode == LSIO_ACTIVE || powerMode == LSIO_SUBACTIVE) && state_q.started
      && segSel[3:1] == 3'b000 |=> portEightOe_n == ~$past(state_q.p8Dir))
    else $error("port eight not functional");

  chk_p9_functional: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (powerMode == LSIO_ACTIVE || powerMode == LSIO_SUBACTIVE) && state_q.started
      && segSel == 4'b0000 && !segExt |=> portNineOut == $past(state_q.p9Data))
    else $error("port nine not functional");

  chk_p9_data_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
      wrEn && paddr == AddrP9Data
      |=> state_q.p9Data == $past(pwdata[7:0]))
    else $error("port nine data write lost");

  chk_p9_stored_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
      rdEn && paddr == AddrP9Data && segSel == 4'b0000 && !segExt && state_q.p9Dir == 8'hFF
      |=> prdata[7:0] == $past(state_q.p9Data))
    else $error("output pins not read from register");

  chk_p9_dir_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
      wrEn && paddr == AddrP9Dir
      |=> state_q.p9Dir == $past(pwdata[7:0]))
    else $error("port nine direction write lost");

  chk_p9_output_en: assert property (@(posedge ref_clk) disable iff (!rst_n)
      segSel == 4'b0000 && !segExt && !hiZ && !holdPins
      |=> portNineOe_n == ~$past(state_q.p9Dir))
    else $error("port nine driver not per direction");

  chk_p9_alt_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
      segSel != 4'b0000 && !hiZ && !holdPins
      |=> portNineOe_n[5:0] == 6'h3F)
    else $error("port nine low pins driven outside I/O");

  chk_p9_alt_pins: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (segSel != 4'b0000 || segExt) && !hiZ && !holdPins
      |=> portNineOe_n[7:6] == 2'h0)
    else $error("port nine high pins not driven");

  chk_p8_dir_ones: assert property (@(posedge ref_clk) disable iff (!rst_n)
      rdEn && paddr == AddrP8Dir
      |=> prdata[7:0] == 8'hFF)
    else $error("port eight direction read not all ones");

  chk_dir_reset_inputs: assert property (@(posedge ref_clk)
      $rose(rst_n)
      |-> state_q.p9Dir == 8'h00 && portNineOe_n == 8'hFF)
    else $error("port nine not inputs after reset");

  chk_p97_segment: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !segExt && segSel != 4'b0000 && !hiZ && !holdPins
      |=> portNineOut[7] == $past(lcdSegNine7) && !portNineOe_n[7])
    else $error("segment forty not on pin");

  chk_p97_gpio: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !segExt && segSel == 4'b0000 && !hiZ && !holdPins
      |=> portNineOe_n[7] == !$past(state_q.p9Dir[7]) && portNineOut[7] == $past(state_q.p9Data[7]))
    else $error("pin seven not I/O");

  chk_p96_segment: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !segExt && segSel != 4'b0000 && !hiZ && !holdPins
      |=> portNineOut[6] == $past(lcdSegNine6) && !portNineOe_n[6])
    else $error("segment thirty-nine not on pin");

  chk_clock_two: assert property (@(posedge ref_clk) disable iff (!rst_n)
      segExt && !hiZ && !holdPins
      |=> portNineOut[6] == $past(lcdClockTwo) && !portNineOe_n[6])
    else $error("clock two not on pin");

  chk_p96_gpio: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !segExt && segSel == 4'b0000 && !hiZ && !holdPins
      |=> portNineOe_n[6] == !$past(state_q.p9Dir[6]) && portNineOut[6] == $past(state_q.p9Data[6]))
    else $error("pin six not I/O");

  chk_p9_drive_data: assert property (@(posedge ref_clk) disable iff (!rst_n)
      segSel == 4'b0000 && !hiZ && !holdPins
      |=> portNineOut[5:0] == $past(state_q.p9Data[5:0]))
    else $error("port nine data not on pins");

  chk_p9_drive_dir: assert property (@(posedge ref_clk) disable iff (!rst_n)
      segSel == 4'b0000 && !segExt && !hiZ && !holdPins
      |=> (~portNineOe_n & ~$past(state_q.p9Dir)) == 8'h00)
    else $error("input pin driven");

  chk_unmapped_err: assert property (@(posedge ref_clk) disable iff (!rst_n)
      psel && penable && paddr == 12'h01C
      |-> pslverr && pready)
    else $error("unmapped access not flagged");

endmodule : lsio_ports

//--- verif/lsio_pin_model.sv
module lsio_pin_model
  import lsio_pkg::*;
(
  input wire logic [PortWidth-1:0] pinOut,
  input wire logic [PortWidth-1:0] pinOe_n,
  input wire logic [PortWidth-1:0] extDrive,
  output logic [PortWidth-1:0] pinLevel
);
  timeunit 1ns;
  timeprecision 1ps;
  // The board drives every pin whose device driver is off
  always_comb begin
    pinLevel = (~pinOe_n & pinOut) | (pinOe_n & extDrive);
  end
endmodule : lsio_pin_model

//--- verif/lsio_ports_tb.sv
module lsio_ports_tb
  import lsio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, seg6 = 1'b0, seg7 = 1'b0, clk1 = 1'b0, clk2 = 1'b0;
  lsio_mode_type powerMode = LSIO_ACTIVE;
  logic [7:0] seg8 = '0, ext8 = 8'h5A, ext9 = 8'hC3, pin8, pin9, out8, out9, oe8, oe9;
  int errors = 0, n_tests = 0;
  always #2 ref_clk = ~ref_clk;
  lsio_ports i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .powerMode(powerMode), .lcdSegEight(seg8), .lcdSegNine6(seg6),
    .lcdSegNine7(seg7), .lcdClockOne(clk1), .lcdClockTwo(clk2), .portEightIn(pin8),
    .portEightOut(out8), .portEightOe_n(oe8), .portNineIn(pin9), .portNineOut(out9),
    .portNineOe_n(oe9));
  lsio_pin_model i_pm8 (.pinOut(out8), .pinOe_n(oe8), .extDrive(ext8), .pinLevel(pin8));
  lsio_pin_model i_pm9 (.pinOut(out9), .pinOe_n(oe9), .extDrive(ext9), .pinLevel(pin9));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  task automatic pm(input lsio_mode_type m);
    @(posedge ref_clk);
    powerMode <= m;
    repeat (2) @(posedge ref_clk);
  endtask : pm
  function automatic logic [7:0] en(input logic [7:0] g, altEn, dir);
    return (g & dir) | (~g & altEn);
  endfunction : en
  // Expected pin level, which is also what a port read returns
  function automatic logic [7:0] lvl(input logic [7:0] g, alt, altEn, dir, data, ext);
    return (g & dir & data) | (~g & altEn & alt) | (~en(g, altEn, dir) & ext);
  endfunction : lvl
  function automatic logic [7:0] gp8(input logic [4:0] c);
    return {{4{c[3:1] == 3'b000}}, {4{c[3:1] == 3'b000 || c[3:0] == 4'b0010}}};
  endfunction : gp8
  task automatic end_sim();
    $display("Comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim
  // Whole run is about 700 cycles, well under the 15000-cycle time limit
  initial begin
    #60000;
    errors++;
    end_sim();
  end
  initial begin
    logic [7:0] g8, g9, a9, d8, r8, d9, r9;
    void'($urandom(32'h7a8e_1aee));
    repeat (12) @(posedge ref_clk);
    chk(32'({oe8, oe9}), 32'h0000_FFFF);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    apb(1'b0, AddrP9Dir, '0);
    chk(rd, 32'h0000_00FF);
    apb(1'b0, AddrP9Data, '0);
    chk(rd, 32'(ext9));
    apb(1'b1, AddrP9Dir, 32'h0000_00FF);
    apb(1'b0, AddrP9Data, '0);
    chk(rd, 32'h0000_0000);
    apb(1'b0, 12'h01C, '0);
    chk(rd, 32'h0000_0000);
    chk(32'(er), 32'h0000_0001);
    $display("reset and map test done");
    for (int i = 0; i < 32; i++) begin
      {d8, r8, d9, r9} = $urandom;
      seg8 <= 8'($urandom);
      ext8 <= 8'($urandom);
      ext9 <= 8'($urandom);
      {seg6, seg7, clk1, clk2} <= 4'($urandom);
      apb(1'b1, AddrLcdCtrl, 32'(i));
      apb(1'b1, AddrP8Dir, 32'(d8));
      apb(1'b1, AddrP8Data, 32'(r8));
      apb(1'b1, AddrP9Dir, 32'(d9));
      apb(1'b1, AddrP9Data, 32'(r9));
      g8 = gp8(5'(i));
      g9 = {{2{i == 0}}, {6{i[3:0] == 4'h0}}};
      a9 = {i[4] ? {clk1, clk2} : {seg7, seg6}, 6'h00};
      @(posedge ref_clk);
      chk(32'(oe8), 32'(8'(~en(g8, 8'hFF, d8))));
      chk(32'(oe9), 32'(8'(~en(g9, 8'hC0, d9))));
      chk(32'(pin8), 32'(lvl(g8, seg8, 8'hFF, d8, r8, ext8)));
      chk(32'(pin9), 32'(lvl(g9, a9, 8'hC0, d9, r9, ext9)));
      @(posedge ref_clk);
      apb(1'b0, AddrP9Data, '0);
      chk(rd, 32'(lvl(g9, a9, 8'hC0, d9, r9, ext9)));
    end
    $display("pin function test done");
    apb(1'b1, AddrLcdCtrl, '0);
    apb(1'b1, AddrP8Dir, 32'h0000_00FF);
    apb(1'b1, AddrP9Dir, 32'h0000_00FF);
    apb(1'b1, AddrP8Data, 32'h0000_0055);
    apb(1'b1, AddrP9Data, 32'h0000_0055);
    pm(LSIO_SLEEP);
    apb(1'b1, AddrP8Data, 32'h0000_00AA);
    apb(1'b1, AddrP9Data, 32'h0000_00AA);
    chk(32'({pin8, pin9}), 32'h0000_5555);
    pm(LSIO_WATCH);
    chk(32'({pin8, pin9}), 32'h0000_5555);
    pm(LSIO_SUBSLEEP);
    chk(32'(pin9), 32'h0000_0055);
    pm(LSIO_STANDBY);
    chk(32'({oe8, oe9}), 32'h0000_FFFF);
    pm(LSIO_SUBACTIVE);
    chk(32'({pin8, pin9}), 32'h0000_AAAA);
    $display("power mode test done");
    end_sim();
  end
endmodule : lsio_ports_tb
